// ==== psram_host_cfg.svh ====
// constants for the pseudo-static ram host controller
// assumes a 25 MHz clock; times are in ns unless named otherwise
`ifndef PSRAM_HOST_CFG_SVH
`define PSRAM_HOST_CFG_SVH

// ==========================================
// clock and timing
`define CLK_PERIOD_NS        40
`define SELECT_TO_END_NS     60
`define LANE_TO_END_NS       60
`define DATA_SETUP_NS        30
`define WRITE_FLOAT_NS       30
`define READ_ACCESS_NS       70
`define DESELECT_MIN_NS      5
`define MAX_SELECT_US        15
// least times round up, the longest rounds down
`define CEIL_CYC(ns)         (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC           `CEIL_CYC(`SELECT_TO_END_NS + 1)
`define FLOAT_SETUP_CYC      `CEIL_CYC(`WRITE_FLOAT_NS + `DATA_SETUP_NS + 1)
`define READ_CYC             `CEIL_CYC(`READ_ACCESS_NS)
`define DESELECT_CYC         `CEIL_CYC(`DESELECT_MIN_NS + 1)
`define MAX_SELECT_CYC       ((`MAX_SELECT_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== psram_host_pkg.sv ====
// types shared by the host controller modules
// assumes psram_host_cfg.svh is compiled alongside
package psram_host_pkg;
	// ==========================================
	// access sequencer states
	typedef enum logic [2:0] {
		st_idle,
		st_setup,
		st_write,
		st_read,
		st_gap
	} state_type;
endpackage

// ==== psram_timer_if.sv ====
// handshake between the sequencer and the select-window timer
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface psram_timer_if;
	logic selected;  // chip currently selected
	logic expired;   // select window used up
	modport seq (output selected, input expired);
	modport tmr (input selected, output expired);
endinterface
`default_nettype wire

// ==== psram_select_timer.sv ====
// counts selected cycles and flags when the count reaches two below the window limit
// assumes synchronous active low reset on clk
`timescale 1ns/1ps
`include "psram_host_cfg.svh"
`default_nettype none
module psram_select_timer #(
	parameter int LIMIT = `MAX_SELECT_CYC  // selected cycles allowed
) (
	input  wire logic    clk,     // system clock
	input  wire logic    resetn,  // synchronous reset, low
	psram_timer_if.tmr   tif      // sequencer handshake
);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] count_q;  // cycles spent selected

	// ==========================================
	// select window counter, cleared on every deselect
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_q <= '0;
		end else if (!tif.selected) begin
			count_q <= '0;
		end else if (count_q != CW'(LIMIT)) begin
			count_q <= count_q + CW'(1);
		end
	end

	// warn one cycle ahead so the deselect lands inside the window
	assign tif.expired = (count_q >= CW'(LIMIT - 2));

	// the chip never stays selected for the whole window
	property p_window;
		@(posedge clk) disable iff (!resetn)
		tif.selected |-> count_q <= CW'(LIMIT - 1);
	endproperty
	a_window: assert property (p_window) else $error("select window exceeded");
endmodule // psram_select_timer
`default_nettype wire

// ==== psram_host.sv ====
// host controller driving an asynchronous 512K x 16 pseudo-static ram
// assumes the user side is synchronous to clk; data pins are two-way
`timescale 1ns/1ps
`include "psram_host_cfg.svh"
`default_nettype none
module psram_host
	import psram_host_pkg::*;
#(
	parameter int AW        = 19,               // address width
	parameter int MAX_SEL   = `MAX_SELECT_CYC   // longest select in cycles
) (
	input  wire logic          clk,                  // system clock
	input  wire logic          resetn,               // synchronous reset, low
	input  wire logic          req_valid,            // access request
	output logic               req_ready,            // request taken
	input  wire logic          req_write,            // 1 write, 0 read
	input  wire logic [AW-1:0] req_addr,             // word address
	input  wire logic [15:0]   req_wdata,            // write data
	input  wire logic [1:0]    req_lanes,            // byte lanes wanted, high active
	output logic               rsp_valid,            // read data pulse
	output logic [15:0]        rsp_rdata,            // read data
	output logic [AW-1:0]      mem_addr,             // address pins
	output logic               primary_select_n,     // chip select, low
	output logic               secondary_select,     // chip select, high
	output logic               write_strobe_n,       // write strobe, low
	output logic               output_drive_n,       // output enable, low
	output logic               upper_lane_select_n,  // upper byte, low
	output logic               lower_lane_select_n,  // lower byte, low
	input  wire logic [15:0]   dq_i,                 // data pins in
	output logic [15:0]        dq_o,                 // data pins out
	output logic               dq_oe                 // data pins driven, high
);
	localparam logic [3:0] STROBE = 4'(`STROBE_CYC > `FLOAT_SETUP_CYC ?
		`STROBE_CYC : `FLOAT_SETUP_CYC);
	localparam logic [3:0] READC  = 4'(`READ_CYC);
	localparam logic [3:0] GAPC   = 4'(`DESELECT_CYC);

	state_type        state_q;   // sequencer state
	logic [3:0]       tick_q;    // phase cycle counter
	logic             wr_q;      // current access is a write
	logic [15:0]      dq1_q;     // data pin sync stage one
	logic [15:0]      dq2_q;     // data pin sync stage two
	psram_timer_if    tif();     // timer handshake

	// ==========================================
	// window timer
	psram_select_timer #(.LIMIT(MAX_SEL)) u_timer (
		.clk    (clk),
		.resetn (resetn),
		.tif    (tif)
	);
	assign tif.selected = !primary_select_n;

	// one access per select, so a limit is a safety net only
	assign req_ready = (state_q == st_idle) && resetn;

	// ==========================================
	// sequencer
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_q <= st_idle;
			tick_q  <= '0;
		end else begin
			case (state_q)
				st_idle: begin
					if (req_valid) begin
						state_q <= st_setup;
						tick_q  <= '0;
					end
				end
				// address settles one cycle before select
				st_setup: begin
					state_q <= wr_q ? st_write : st_read;
					tick_q  <= '0;
				end
				st_write: begin
					tick_q <= tick_q + 4'd1;
					// strobe and primary select end together; lanes clear one cycle later
					if (tick_q == STROBE - 4'd1 || tif.expired) begin
						state_q <= st_gap;
						tick_q  <= '0;
					end
				end
				st_read: begin
					tick_q <= tick_q + 4'd1;
					if (tick_q == READC + 4'd1 || tif.expired) begin
						state_q <= st_gap;
						tick_q  <= '0;
					end
				end
				// deselect gap lets the device refresh
				st_gap: begin
					tick_q <= tick_q + 4'd1;
					if (tick_q == GAPC - 4'd1) begin
						state_q <= st_idle;
					end
				end
				default: begin
					state_q <= st_idle;
				end
			endcase
		end
	end

	// ==========================================
	// request capture; address and data held through the access
	always_ff @(posedge clk) begin
		if (!resetn) begin
			wr_q                <= 1'b0;
			mem_addr            <= '0;
			dq_o                <= 16'h0000;
			upper_lane_select_n <= 1'b1;
			lower_lane_select_n <= 1'b1;
		end else if (req_ready && req_valid) begin
			wr_q                <= req_write;
			mem_addr            <= req_addr;
			dq_o                <= req_wdata;
			upper_lane_select_n <= !req_lanes[1];
			lower_lane_select_n <= !req_lanes[0];
		end else if (state_q == st_gap) begin
			upper_lane_select_n <= 1'b1;
			lower_lane_select_n <= 1'b1;
		end
	end

	// ==========================================
	// pin controls, registered from the next state
	always_ff @(posedge clk) begin
		if (!resetn) begin
			primary_select_n <= 1'b1;
			secondary_select <= 1'b0;
			write_strobe_n   <= 1'b1;
			output_drive_n   <= 1'b1;
			dq_oe            <= 1'b0;
		end else begin
			primary_select_n <= !(state_q == st_setup ||
				(state_q == st_write && !(tick_q == STROBE - 4'd1 || tif.expired)) ||
				(state_q == st_read && !(tick_q == READC + 4'd1 || tif.expired)));
			secondary_select <= 1'b1;
			// strobe only for writes, dropped with the select
			write_strobe_n   <= !((state_q == st_setup && wr_q) ||
				(state_q == st_write && !(tick_q == STROBE - 4'd1 || tif.expired)));
			output_drive_n   <= !((state_q == st_setup && !wr_q) ||
				(state_q == st_read && !(tick_q == READC + 4'd1 || tif.expired)));
			// data driven from select through two cycles past the end
			dq_oe            <= (state_q == st_setup && wr_q) || state_q == st_write ||
				(state_q == st_gap && wr_q && tick_q == 4'd0);
		end
	end

	// ==========================================
	// read data path through two flops
	always_ff @(posedge clk) begin
		if (!resetn) begin
			dq1_q     <= 16'h0000;
			dq2_q     <= 16'h0000;
			rsp_rdata <= 16'h0000;
			rsp_valid <= 1'b0;
		end else begin
			dq1_q     <= dq_i;
			dq2_q     <= dq1_q;
			rsp_valid <= (state_q == st_read && tick_q == READC + 4'd1);
			if (state_q == st_read && tick_q == READC + 4'd1) begin
				rsp_rdata <= dq2_q;
			end
		end
	end

	// ==========================================
	// checks
	property p_read_strobe;
		@(posedge clk) disable iff (!resetn)
		!output_drive_n |-> write_strobe_n;
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("strobe low in read");

	property p_addr_stable;
		@(posedge clk) disable iff (!resetn)
		!primary_select_n && !$past(primary_select_n) |-> $stable(mem_addr);
	endproperty
	a_addr_stable: assert property (p_addr_stable) else $error("address moved");

	property p_end_together;
		@(posedge clk) disable iff (!resetn)
		$rose(write_strobe_n) |-> primary_select_n;
	endproperty
	a_end_together: assert property (p_end_together) else $error("strobe ended alone");

	property p_strobe_width;
		@(posedge clk) disable iff (!resetn)
		$fell(write_strobe_n) |-> !write_strobe_n [*2];
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("strobe too short");

	property p_data_setup;
		@(posedge clk) disable iff (!resetn)
		!write_strobe_n |-> dq_oe && $stable(dq_o);
	endproperty
	a_data_setup: assert property (p_data_setup) else $error("data not held");

	property p_gap;
		@(posedge clk) disable iff (!resetn)
		$rose(primary_select_n) |=> primary_select_n;
	endproperty
	a_gap: assert property (p_gap) else $error("no deselect gap");

	property p_lanes;
		@(posedge clk) disable iff (!resetn)
		!write_strobe_n |-> $stable(upper_lane_select_n) && $stable(lower_lane_select_n);
	endproperty
	a_lanes: assert property (p_lanes) else $error("lanes moved in write");

	// select already low two edges before the strobe ends the write
	property p_sel_lead;
		@(posedge clk) disable iff (!resetn)
		$rose(write_strobe_n) |-> !$past(primary_select_n, 2);
	endproperty
	a_sel_lead: assert property (p_sel_lead) else $error("select too short");

	// at least one lane already active two edges before the write ends
	property p_lane_lead;
		@(posedge clk) disable iff (!resetn)
		$rose(write_strobe_n) |->
			!($past(upper_lane_select_n, 2) && $past(lower_lane_select_n, 2));
	endproperty
	a_lane_lead: assert property (p_lane_lead) else $error("lanes too short");

	property p_read_done;
		@(posedge clk) disable iff (!resetn)
		$fell(output_drive_n) |-> ##[1:8] rsp_valid;
	endproperty
	a_read_done: assert property (p_read_done) else $error("read never answered");
endmodule // psram_host
`default_nettype wire

// ==== psram_model.sv ====
// behavioural 512K x 16 pseudo-static ram seen at the host pins
// assumes pins settle between host clock edges; no clock of its own
`timescale 1ns/1ps
`default_nettype none
module psram_model (
	input  wire logic [18:0] mem_addr,            // address pins
	input  wire logic        primary_select_n,    // select, low
	input  wire logic        secondary_select,    // select, high
	input  wire logic        write_strobe_n,      // strobe, low
	input  wire logic        output_drive_n,      // output on, low
	input  wire logic        upper_lane_select_n, // upper byte, low
	input  wire logic        lower_lane_select_n, // lower byte, low
	input  wire logic [15:0] dq,                  // pin level
	output logic      [15:0] dq_dev,              // device drive value
	output logic             drive,               // device drives pins
	output int               refreshes,           // refreshes done
	output logic             lost                 // contents lost
);
	logic [15:0] mem [0:524287];    // storage, one word per address
	logic [15:0] last = 16'h0000;   // last value driven
	realtime     t_sel = 0.0;       // time of last select
	realtime     t_des = 0.0;       // time of last deselect
	wire sel   = !primary_select_n && secondary_select;
	wire wr    = sel && !write_strobe_n;
	wire wr_hi = wr && !upper_lane_select_n;
	wire wr_lo = wr && !lower_lane_select_n;
	// released pins show the inverse of the last value
	assign drive  = sel && !output_drive_n && write_strobe_n;
	assign dq_dev = drive ? mem[mem_addr] : ~last;
	initial begin
		refreshes = 0;
		lost = 1'b0;
	end
	// each byte is stored when its own write ends
	always @(negedge wr_hi) mem[mem_addr][15:8] = dq[15:8];
	always @(negedge wr_lo) mem[mem_addr][7:0] = dq[7:0];
	always @(negedge drive) last = mem[mem_addr];
	// refresh runs only in a deselect gap over 5 ns
	always @(posedge sel) begin
		if ($realtime - t_des > 5.0) refreshes++;
		t_sel = $realtime;
	end
	// no refresh within 15 us of selection loses the contents
	always @(negedge sel) begin
		t_des = $realtime;
		if (t_des - t_sel > 15000.0) lost = 1'b1;
	end
endmodule // psram_model
`default_nettype wire

// ==== tb.sv ====
// self-checking bench for psram_host against the ram model
// assumes the design files and psram_model.sv are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct packed {
		logic w; logic [18:0] a; logic [15:0] d; logic [1:0] l; logic [15:0] e;
	} row_type;
	// ==========================================
	// stimulus table: write, addr, data, lanes, expected read
	row_type rows [7] = '{
		'{1'b1, 19'h00001, 16'ha5c3, 2'h3, 16'h0000},
		'{1'b1, 19'h7ffff, 16'h1234, 2'h3, 16'h0000},
		'{1'b0, 19'h00001, 16'h0000, 2'h3, 16'ha5c3},
		'{1'b0, 19'h7ffff, 16'h0000, 2'h3, 16'h1234},
		'{1'b1, 19'h00001, 16'h55ee, 2'h2, 16'h0000},
		'{1'b1, 19'h00001, 16'h0077, 2'h1, 16'h0000},
		'{1'b0, 19'h00001, 16'h0000, 2'h3, 16'h5577}};
	logic clk = 0, resetn = 0, req_valid = 0, req_write = 0;   // bench drives
	logic [18:0] req_addr = 19'h00000, mem_addr, a_q;         // addresses
	logic [15:0] req_wdata = 16'h0000, rsp_rdata, dq_o, dq_dev, d_q;
	logic [1:0]  req_lanes = 2'h0;                            // lanes wanted
	logic req_ready, rsp_valid, primary_select_n, secondary_select, write_strobe_n;
	logic output_drive_n, upper_lane_select_n, lower_lane_select_n, dq_oe, drive, lost;
	logic sel_q = 0, wr_q = 0;                                // last monitor sample
	int   fails = 0, checks = 0, refreshes, sel_n = 0, wl = 0, gap = 100, rises = 0;
	wire [15:0] dq = dq_oe ? dq_o : dq_dev;                   // pin level
	psram_host #(.MAX_SEL(5)) u_dut (.clk(clk), .resetn(resetn),
		.req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_lanes(req_lanes),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
		.primary_select_n(primary_select_n), .secondary_select(secondary_select),
		.write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
		.upper_lane_select_n(upper_lane_select_n),
		.lower_lane_select_n(lower_lane_select_n),
		.dq_i(dq), .dq_o(dq_o), .dq_oe(dq_oe));
	psram_model u_ram (.mem_addr(mem_addr), .primary_select_n(primary_select_n),
		.secondary_select(secondary_select), .write_strobe_n(write_strobe_n),
		.output_drive_n(output_drive_n), .upper_lane_select_n(upper_lane_select_n),
		.lower_lane_select_n(lower_lane_select_n), .dq(dq), .dq_dev(dq_dev),
		.drive(drive), .refreshes(refreshes), .lost(lost));
	initial forever #20 clk = ~clk;
	// ==========================================
	// compares and verdict
	task chk_d(input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task chk_b(input logic got, exp);
		chk_d({15'h0000, got}, {15'h0000, exp});
	endtask
	task stop_test;
		if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait for a flag, sampled at the falling edge
	task automatic wait_for(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 60) begin
				fails++;
				stop_test;
			end
		end
	endtask
	// one request held until taken; reads compare the returned word
	task automatic access(input row_type r);
		@(posedge clk);
		req_valid <= 1'b1;
		req_write <= r.w;
		req_addr <= r.a;
		req_wdata <= r.d;
		req_lanes <= r.l;
		@(negedge clk);
		wait_for(req_ready);
		@(posedge clk);
		req_valid <= 1'b0;
		if (!r.w) begin
			@(negedge clk);
			wait_for(rsp_valid);
			chk_d(rsp_rdata, r.e);
		end
	endtask
	// pins parked while reset is held
	task rst_chk;
		chk_b(primary_select_n, 1'b1);
		chk_b(secondary_select, 1'b0);
		chk_b(write_strobe_n, 1'b1);
		chk_b(output_drive_n, 1'b1);
		chk_b(upper_lane_select_n & lower_lane_select_n, 1'b1);
		chk_b(rsp_valid, 1'b0);
		chk_b(dq_oe, 1'b0);
		chk_b(req_ready, 1'b0);
	endtask
	// ==========================================
	// pin monitor: host side timing in clock cycles
	always @(negedge clk) begin : mon
		logic s, w;
		s = !primary_select_n && secondary_select;
		w = s && !write_strobe_n;
		if (resetn) begin
			if (!output_drive_n) chk_b(write_strobe_n, 1'b1);
			if (s && sel_q) chk_b(mem_addr === a_q, 1'b1);
			// a window of 5 leaves at most 4 selected cycles
			if (s) chk_b(sel_n < 4, 1'b1);
			if (w) chk_b(upper_lane_select_n & lower_lane_select_n, 1'b0);
			if (drive) chk_b(dq_oe, 1'b0);
			if (s && !sel_q) chk_b(gap >= 1, 1'b1);
			if (w && wr_q) chk_d(dq_o, d_q);
			if (w) chk_b(dq_oe, 1'b1);
			if (!w && wr_q) chk_b(wl >= 2, 1'b1);
		end
		if (s && !sel_q) rises++;
		sel_n = s ? sel_n + 1 : 0;
		gap = s ? 0 : gap + 1;
		wl = w ? wl + 1 : 0;
		sel_q = s;
		wr_q = w;
		a_q = mem_addr;
		d_q = dq_o;
	end
	// ==========================================
	// main sequence: table, reset in mid-write, refresh tally
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst_chk;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) access(rows[i]);
		// write cut by a reset two edges after it is taken
		access(row_type'{1'b1, 19'h00002, 16'hbeef, 2'h3, 16'h0000});
		repeat (2) @(posedge clk);
		resetn <= 1'b0;
		@(negedge clk);
		@(negedge clk);
		rst_chk;
		@(posedge clk);
		resetn <= 1'b1;
		access(rows[6]);
		repeat (4) @(posedge clk);
		chk_b(lost, 1'b0);
		chk_d(16'(refreshes), 16'(rises));
		stop_test;
	end
endmodule // tb
`default_nettype wire
